//--- logic/serial_rx_consts.vh
`ifndef SERIAL_RX_CONSTS_VH
`define SERIAL_RX_CONSTS_VH

// ==========================================================
// Register indices (byte address is four times the index)
`define IDX_IRQ_FLAGS      8'h0c
`define IDX_RX_STATUS      8'h18
`define IDX_TX_BUFFER      8'h19
`define IDX_RX_BUFFER      8'h1a
`define IDX_IRQ_ENABLES    8'h8c
`define IDX_TX_STATUS      8'h98
`define IDX_BAUD_DIVISOR   8'h99

// ==========================================================
// Reset values
`define RST_BYTE           8'h00
`define RST_TX_STATUS      8'h02

// ==========================================================
// Field positions
`define BIT_RX_READY       5
`define BIT_RX_IRQ_EN      5
`define BIT_PORT_EN        7
`define BIT_NINE_BIT       6
`define BIT_SINGLE_RX      5
`define BIT_CONT_RX        4
`define BIT_FRAME_ERR      2
`define BIT_OVERRUN        1
`define BIT_NINTH          0
`define BIT_CLK_SRC        7
`define BIT_SYNC_SEL       4
`define BIT_HIGH_SPEED     2
`define BIT_SHIFT_EMPTY    1

// Writable masks of mixed registers
`define MASK_TX_STATUS     8'hf5

// ==========================================================
// Oversampling, frame and buffer figures
`define OVS_LAST           4'hf
`define OVS_SAMPLE_A       4'h6
`define OVS_SAMPLE_B       4'h7
`define OVS_SAMPLE_C       4'h8
`define PRESCALE_LAST      2'h3
`define BITS_EIGHT         4'h8
`define BITS_NINE          4'h9
`define FIFO_DEPTH         2'h2

// AHB transfer type bit marking NONSEQ or SEQ
`define HTRANS_ACTIVE_BIT  1

`endif

//--- logic/serial_async_receiver.v
// Notes on behaviour
// - Line recovered at sixteen samples per bit; main shifter moves once per bit.
// - Asynchronous frames accepted only while continuous receive enable is set.
// - After stop bit, word moves into buffer if room; ready flag then set.
// - Receive interrupt only when ready flag and receive interrupt enable both set.
// - Ready flag read-only; clears only when buffer read and empty.
// - Two-entry FIFO buffer; third word may shift in; each read pops.
// - Buffer full at further stop bit sets overrun and drops that word.
// - Overrun clears only by clearing continuous receive enable; software re-enables.
// - While overrun set, no word moves from shifter into buffer.
// - Stop bit sampled low sets the framing error flag for that word.
// - Framing error and ninth bit kept per entry; popping shows next entry's.
// - Synchronous master mode is half duplex; data line released while receiving.
// - Sync select picks synchronous mode; port enable assigns clock and data pins.
// - Clock source select makes the device master, driving the shift clock.
// - Unimplemented register bits read back as zero.
// - Each bit decided by majority of samples seven, eight and nine.
// - Frames NRZ, one start, eight or nine data bits, one stop, LSB first.
//
// The AHB-Lite interface to the registers was decided locally.
`include "serial_rx_consts.vh"

module serial_async_receiver (
    // Clock and reset
    input  wire        CLK,
    input  wire        RESET_N,
    // AHB-Lite slave
    input  wire        HSEL,
    input  wire [31:0] HADDR,
    input  wire [1:0]  HTRANS,
    input  wire        HWRITE,
    input  wire [2:0]  HSIZE,
    input  wire [31:0] HWDATA,
    input  wire        HREADY,
    output reg  [31:0] HRDATA,
    output reg         HREADYOUT,
    output reg         HRESP,
    // Interrupt request
    output reg         RX_IRQ,
    // Receive / data line
    input  wire        DATA_IN,
    output reg         DATA_OUT,
    output reg         DATA_OE,
    // Shift clock line
    output reg         SCLK_OUT,
    output reg         SCLK_OE
);

    // ==========================================================
    // Receiver states (one-hot)
    localparam [3:0] ST_IDLE  = 4'b0001;
    localparam [3:0] ST_START = 4'b0010;
    localparam [3:0] ST_DATA  = 4'b0100;
    localparam [3:0] ST_STOP  = 4'b1000;

    // Software-visible storage
    reg  [7:0] rx_status_q;      // bits 7..4 only
    reg  [7:0] irq_enables_q;
    reg  [7:0] tx_status_q;
    reg  [7:0] tx_buffer_q;
    reg  [7:0] baud_divisor_q;
    reg        overrun_q;

    // Bus pipeline
    reg        pend_q;
    reg        pend_write_q;
    reg  [7:0] pend_idx_q;

    // Line synchroniser
    reg        line_meta_q;
    reg        line_sync_q;
    reg        line_prev_q;

    // Baud generation
    reg  [7:0] brg_cnt_q;
    reg  [1:0] pre_q;

    // Receive engine
    reg  [3:0] state_q;
    reg  [3:0] ovs_q;
    reg  [3:0] bit_cnt_q;
    reg  [8:0] shift_q;
    reg  [1:0] samp_q;

    // Two-entry buffer: {frame error, ninth bit, data}
    reg  [9:0] fifo_q [0:1];
    reg  [1:0] count_q;

    // ==========================================================
    // Mode decode
    wire port_en    = rx_status_q[`BIT_PORT_EN];
    wire nine_bit   = rx_status_q[`BIT_NINE_BIT];
    wire single_rx  = rx_status_q[`BIT_SINGLE_RX];
    wire cont_rx    = rx_status_q[`BIT_CONT_RX];
    wire sync_sel   = tx_status_q[`BIT_SYNC_SEL];
    wire clk_src    = tx_status_q[`BIT_CLK_SRC];
    wire high_speed = tx_status_q[`BIT_HIGH_SPEED];

    wire async_on = port_en & ~sync_sel & cont_rx;
    // sync mode with port enabled; master drives clock
    wire sync_on  = port_en & sync_sel & clk_src & (cont_rx | single_rx);
    wire rx_on    = async_on | sync_on;
    wire [3:0] bits_needed = nine_bit ? `BITS_NINE : `BITS_EIGHT;

    // Bus handshake decode
    wire addr_take = HSEL & HREADY & HTRANS[`HTRANS_ACTIVE_BIT];
    wire do_write  = pend_q & pend_write_q;
    wire do_read   = pend_q & ~pend_write_q;
    wire pop       = do_read & (pend_idx_q == `IDX_RX_BUFFER) & (count_q != 2'h0);

    // ==========================================================
    // Baud tick and sixteen-times tick
    wire brg_tick = rx_on & (brg_cnt_q == 8'h00);
    // oversample tick, slowed by four at low speed
    wire ovs_tick = brg_tick & ~sync_sel & (high_speed | (pre_q == `PRESCALE_LAST));

    // Majority of three samples
    wire vote = (samp_q[1] & samp_q[0]) | (samp_q[1] & line_sync_q)
              | (samp_q[0] & line_sync_q);
    wire decide = ovs_tick & (ovs_q == `OVS_SAMPLE_C);
    wire ovs_end = ovs_tick & (ovs_q == `OVS_LAST);

    // Sync master: falling shift-clock edge samples data
    wire sync_fall = sync_on & brg_tick & SCLK_OUT;

    // Word completion
    wire async_done = (state_q == ST_STOP) & decide & async_on;
    wire sync_done  = sync_fall & (bit_cnt_q == bits_needed - 4'h1);
    wire word_done  = async_done | sync_done;

    // Assembled word, eight-bit frames sit one place high
    wire [8:0] sync_word = {line_sync_q, shift_q[8:1]};
    wire [8:0] src_word  = async_done ? shift_q : sync_word;
    wire [7:0] word_data = nine_bit ? src_word[7:0] : src_word[8:1];
    wire       word_ninth = nine_bit ? src_word[8] : 1'b0;
    // stop bit low is a framing error
    wire       word_framing_error_flag = async_done & ~vote;

    // overrun blocks transfers; a full buffer refuses
    wire room  = (count_q != `FIFO_DEPTH) | pop;
    wire push  = word_done & ~overrun_q & room;

    // ==========================================================
    // Two-flop line synchroniser and edge history
    always @(posedge CLK) begin
        if (!RESET_N) begin
            line_meta_q <= 1'b1;
            line_sync_q <= 1'b1;
            line_prev_q <= 1'b1;
        end else begin
            line_meta_q <= DATA_IN;
            line_sync_q <= line_meta_q;
            line_prev_q <= line_sync_q;
        end
    end

    // ==========================================================
    // Baud rate generator, held in reset while receive is off
    always @(posedge CLK) begin
        if (!RESET_N || !rx_on) begin
            brg_cnt_q <= `RST_BYTE;
            pre_q     <= 2'h0;
        end else if (brg_cnt_q == 8'h00) begin
            brg_cnt_q <= baud_divisor_q;
            pre_q     <= pre_q + 2'h1;
        end else begin
            brg_cnt_q <= brg_cnt_q - 8'h01;
        end
    end

    // ==========================================================
    // Master shift clock; idles high, toggles each baud tick
    always @(posedge CLK) begin
        if (!RESET_N) begin
            SCLK_OUT <= 1'b1;
            SCLK_OE  <= 1'b0;
            DATA_OUT <= 1'b0;
            DATA_OE  <= 1'b0;
        end else begin
            SCLK_OE  <= port_en & sync_sel & clk_src;
            DATA_OE  <= 1'b0;
            DATA_OUT <= 1'b0;
            if (!sync_on)
                SCLK_OUT <= 1'b1;
            else if (brg_tick)
                SCLK_OUT <= ~SCLK_OUT;
        end
    end

    // ==========================================================
    // Receive engine; clearing the enable resets it
    always @(posedge CLK) begin
        if (!RESET_N || !rx_on) begin
            state_q   <= ST_IDLE;
            ovs_q     <= 4'h0;
            bit_cnt_q <= 4'h0;
            shift_q   <= 9'h000;
            samp_q    <= 2'h3;
        end else if (sync_on) begin
            // Sync master: shift on each falling clock edge
            if (sync_fall) begin
                shift_q   <= sync_word;
                bit_cnt_q <= sync_done ? 4'h0 : bit_cnt_q + 4'h1;
            end
        end else begin
            if (ovs_tick && (ovs_q == `OVS_SAMPLE_A || ovs_q == `OVS_SAMPLE_B))
                samp_q <= {samp_q[0], line_sync_q};
            if (ovs_tick)
                ovs_q <= ovs_q + 4'h1;
            case (state_q)
                ST_IDLE: begin
                    ovs_q <= 4'h0;
                    if (line_prev_q && !line_sync_q)
                        state_q <= ST_START;
                end
                ST_START: begin
                    if (decide && vote)
                        state_q <= ST_IDLE;
                    else if (ovs_end)
                        state_q <= ST_DATA;
                end
                ST_DATA: begin
                    // LSB first, shifted in from the top
                    if (decide) begin
                        shift_q   <= {vote, shift_q[8:1]};
                        bit_cnt_q <= bit_cnt_q + 4'h1;
                    end
                    if (ovs_end && bit_cnt_q == bits_needed)
                        state_q <= ST_STOP;
                end
                ST_STOP: begin
                    // Leave at mid stop bit to catch a prompt next start
                    if (decide) begin
                        state_q   <= ST_IDLE;
                        bit_cnt_q <= 4'h0;
                    end
                end
                default: state_q <= ST_IDLE;
            endcase
        end
    end

    // ==========================================================
    // Receive buffer, overrun and flags
    always @(posedge CLK) begin
        if (!RESET_N) begin
            count_q   <= 2'h0;
            fifo_q[0] <= 10'h000;
            fifo_q[1] <= 10'h000;
            overrun_q <= 1'b0;
        end else begin
            // pop on read, push from the shifter
            case ({push, pop})
                2'b10: begin
                    fifo_q[count_q[0]] <= {word_framing_error_flag, word_ninth, word_data};
                    count_q <= count_q + 2'h1;
                end
                2'b01: begin
                    // Vacated slot emptied, so an empty head shows no stale flags
                    fifo_q[0] <= fifo_q[1];
                    fifo_q[1] <= 10'h000;
                    count_q   <= count_q - 2'h1;
                end
                2'b11: begin
                    if (count_q == 2'h1) begin
                        fifo_q[0] <= {word_framing_error_flag, word_ninth, word_data};
                    end else begin
                        fifo_q[0] <= fifo_q[1];
                        fifo_q[1] <= {word_framing_error_flag, word_ninth, word_data};
                    end
                end
                default: count_q <= count_q;
            endcase
            // overrun cleared only with continuous enable low
            if (!cont_rx)
                overrun_q <= 1'b0;
            // full buffer at word end sets overrun
            else if (word_done && !room)
                overrun_q <= 1'b1;
        end
    end

    // ==========================================================
    // Bus address phase capture; one wait state per transfer
    always @(posedge CLK) begin
        if (!RESET_N) begin
            pend_q       <= 1'b0;
            pend_write_q <= 1'b0;
            pend_idx_q   <= 8'h00;
            HREADYOUT    <= 1'b1;
            HRESP        <= 1'b0;
        end else begin
            HRESP <= 1'b0;
            if (addr_take && !pend_q) begin
                pend_q       <= 1'b1;
                pend_write_q <= HWRITE;
                pend_idx_q   <= HADDR[9:2];
                HREADYOUT    <= 1'b0;
            end else begin
                pend_q    <= 1'b0;
                HREADYOUT <= 1'b1;
            end
        end
    end

    // ==========================================================
    // Register writes in the data phase
    always @(posedge CLK) begin
        if (!RESET_N) begin
            rx_status_q    <= `RST_BYTE;
            irq_enables_q  <= `RST_BYTE;
            tx_status_q    <= `RST_TX_STATUS;
            tx_buffer_q    <= `RST_BYTE;
            baud_divisor_q <= `RST_BYTE;
        end else begin
            if (do_write) begin
                case (pend_idx_q)
                    `IDX_RX_STATUS:    rx_status_q    <= {HWDATA[7:4], 4'h0};
                    `IDX_TX_BUFFER:    tx_buffer_q    <= HWDATA[7:0];
                    `IDX_IRQ_ENABLES:  irq_enables_q  <= HWDATA[7:0];
                    `IDX_TX_STATUS:    tx_status_q    <= HWDATA[7:0] & `MASK_TX_STATUS;
                    `IDX_BAUD_DIVISOR: baud_divisor_q <= HWDATA[7:0];
                    default:           baud_divisor_q <= baud_divisor_q;
                endcase
            end
            // Single receive ends itself after one word
            if (sync_done && !cont_rx)
                rx_status_q[`BIT_SINGLE_RX] <= 1'b0;
        end
    end

    // ==========================================================
    // Read data and interrupt line
    always @(posedge CLK) begin
        if (!RESET_N) begin
            HRDATA <= 32'h0000_0000;
            RX_IRQ <= 1'b0;
        end else begin
            // interrupt gated by enable; flag follows buffer
            RX_IRQ <= (count_q != 2'h0) & irq_enables_q[`BIT_RX_IRQ_EN];
            HRDATA <= 32'h0000_0000;
            // unimplemented bits and unmapped words read zero
            if (do_read) begin
                case (pend_idx_q)
                    // ready flag shows a filled buffer
                    `IDX_IRQ_FLAGS:
                        HRDATA[`BIT_RX_READY] <= (count_q != 2'h0);
                    // head entry's error and ninth bit
                    `IDX_RX_STATUS:
                        HRDATA[7:0] <= {rx_status_q[7:4], 1'b0, fifo_q[0][9],
                                        overrun_q, fifo_q[0][8]};
                    `IDX_TX_BUFFER:    HRDATA[7:0] <= tx_buffer_q;
                    `IDX_RX_BUFFER:    HRDATA[7:0] <= fifo_q[0][7:0];
                    `IDX_IRQ_ENABLES:  HRDATA[7:0] <= irq_enables_q;
                    // No transmitter here, so the shifter always reads empty
                    `IDX_TX_STATUS:
                        HRDATA[7:0] <= tx_status_q | (8'h01 << `BIT_SHIFT_EMPTY);
                    `IDX_BAUD_DIVISOR: HRDATA[7:0] <= baud_divisor_q;
                    default:           HRDATA <= 32'h0000_0000;
                endcase
            end
        end
    end

endmodule

//--- tb/serial_rx_chk.sv
module serial_rx_chk (
    // Clock and reset
    input wire logic        CLK,
    input wire logic        RESET_N,
    // Bus
    input wire logic        HSEL,
    input wire logic [31:0] HADDR,
    input wire logic [1:0]  HTRANS,
    input wire logic        HWRITE,
    input wire logic [31:0] HWDATA,
    input wire logic        HREADY,
    input wire logic [31:0] HRDATA,
    input wire logic        HREADYOUT,
    // Serial side
    input wire logic        RX_IRQ,
    input wire logic        DATA_OE,
    input wire logic        SCLK_OE
);
    timeunit 1ns;
    timeprecision 100ps;
    // ==========
    // Shadow of register writes, needed to judge outputs
    logic       ph_q, wr_q, ie_q, pe_q, sy_q, cs_q;
    logic [7:0] ix_q;
    wire        take = HSEL & HREADY & HTRANS[1];
    wire        done = ph_q & HREADYOUT;
    wire        rd   = done & ~wr_q;
    wire        own  = pe_q & sy_q & cs_q;
    always_ff @(posedge CLK) begin
        if (!RESET_N) begin
            {ph_q, wr_q, ie_q, pe_q, sy_q, cs_q} <= 6'h00;
            ix_q <= 8'h00;
        end else begin
            if (take) begin
                wr_q <= HWRITE;
                ix_q <= HADDR[9:2];
            end
            ph_q <= take | (ph_q & ~done);
            if (done && wr_q && ix_q == 8'h8c)
                ie_q <= HWDATA[5];
            if (done && wr_q && ix_q == 8'h18)
                pe_q <= HWDATA[7];
            if (done && wr_q && ix_q == 8'h98) begin
                sy_q <= HWDATA[4];
                cs_q <= HWDATA[7];
            end
        end
    end
    // ==========
    // Properties
    default clocking @(posedge CLK); endclocking
    default disable iff (!RESET_N);
    property p_one_wait; take |=> !HREADYOUT ##1 HREADYOUT; endproperty
    a_one_wait: assert property (p_one_wait)
        else $error("bus wait state count wrong");
    property p_irq_gate; RX_IRQ |-> $past(ie_q); endproperty
    a_irq_gate: assert property (p_irq_gate)
        else $error("request raised while disabled");
    property p_release; !DATA_OE; endproperty
    a_release: assert property (p_release)
        else $error("data line driven during receive");
    property p_sclk_own; SCLK_OE |-> own || $past(own); endproperty
    a_sclk_own: assert property (p_sclk_own)
        else $error("clock driven without master mode");
    property p_sclk_idle; (!own) [*3] |-> !SCLK_OE; endproperty
    a_sclk_idle: assert property (p_sclk_idle)
        else $error("clock pin kept after mode left");
    property p_hi_zero; HRDATA[31:8] == 24'h000000; endproperty
    a_hi_zero: assert property (p_hi_zero)
        else $error("upper read bits not zero");
    property p_flags_rsvd; rd && ix_q == 8'h0c |-> (HRDATA[7:0] & 8'hdf) == 8'h00; endproperty
    a_flags_rsvd: assert property (p_flags_rsvd)
        else $error("flag register spare bits set");
    property p_rxs_rsvd; rd && ix_q == 8'h18 |-> !HRDATA[3]; endproperty
    a_rxs_rsvd: assert property (p_rxs_rsvd)
        else $error("receive status bit 3 set");
    property p_txs_rsvd; rd && ix_q == 8'h98 |-> HRDATA[1] && !HRDATA[3]; endproperty
    a_txs_rsvd: assert property (p_txs_rsvd)
        else $error("transmit status fixed bits wrong");
endmodule

bind serial_async_receiver serial_rx_chk u_chk (
    .CLK(CLK), .RESET_N(RESET_N), .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS),
    .HWRITE(HWRITE), .HWDATA(HWDATA), .HREADY(HREADY), .HRDATA(HRDATA),
    .HREADYOUT(HREADYOUT), .RX_IRQ(RX_IRQ), .DATA_OE(DATA_OE), .SCLK_OE(SCLK_OE)
);

//--- tb/serial_line_model.sv
module serial_line_model (
    // Clock
    input  wire logic CLK,
    // Line toward the device
    output logic      DATA_IN
);
    timeunit 1ns;
    timeprecision 100ps;
    // ==========
    // Remote sender; line rests high between frames
    initial DATA_IN = 1'b1;
    // start low, data LSB first, stop
    task automatic send(input logic [8:0] d, input int nb, input logic stp, input int per);
        for (int i = 0; i < nb + 2; i++) begin
            DATA_IN <= (i == 0) ? 1'b0 : (i > nb) ? stp : d[i - 1];
            repeat (per) @(posedge CLK);
        end
        DATA_IN <= 1'b1;
        repeat (2 * per) @(posedge CLK);
    endtask
endmodule

//--- tb/serial_async_receiver_bench.sv
module serial_async_receiver_bench;
    timeunit 1ns;
    timeprecision 100ps;
    // ==========
    // Signals
    logic        CLK = 1'b0;
    logic        RESET_N = 1'b0;
    logic        HSEL = 1'b0;
    logic [31:0] HADDR = 32'h0;
    logic [1:0]  HTRANS = 2'h0;
    logic        HWRITE = 1'b0;
    logic [31:0] HWDATA = 32'h0;
    wire  [31:0] HRDATA;
    wire         HREADYOUT, HRESP, RX_IRQ, DATA_IN, DATA_OUT, DATA_OE, SCLK_OUT, SCLK_OE;
    int          err_total = 0;
    int          n_tests = 0;
    int          tg;
    logic        sclk_l;
    logic [7:0]  rv;
    logic [7:0]  ix_tab [8] = '{8'h0c, 8'h18, 8'h19, 8'h1a, 8'h8c, 8'h98, 8'h99, 8'h1b};
    logic [7:0]  rst_tab [8] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h02, 8'h00, 8'h00};
    // 200 MHz clock
    always #2.5 CLK = ~CLK;
    // ==========
    // Device and remote sender; bus ready loops back
    serial_async_receiver u_dut (
        .CLK(CLK), .RESET_N(RESET_N), .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS),
        .HWRITE(HWRITE), .HSIZE(3'h2), .HWDATA(HWDATA), .HREADY(HREADYOUT),
        .HRDATA(HRDATA), .HREADYOUT(HREADYOUT), .HRESP(HRESP), .RX_IRQ(RX_IRQ),
        .DATA_IN(DATA_IN), .DATA_OUT(DATA_OUT), .DATA_OE(DATA_OE), .SCLK_OUT(SCLK_OUT),
        .SCLK_OE(SCLK_OE)
    );
    serial_line_model u_line (.CLK(CLK), .DATA_IN(DATA_IN));
    // ==========
    // Bus transfer: address held until taken, data until ready
    task automatic xfer(input logic w, input logic [7:0] ix, input logic [7:0] wd);
        HSEL   <= 1'b1;
        HTRANS <= 2'h2;
        HWRITE <= w;
        HADDR  <= {22'h0, ix, 2'b00};
        @(posedge CLK);
        while (HREADYOUT !== 1'b1) @(posedge CLK);
        HSEL   <= 1'b0;
        HTRANS <= 2'h0;
        HWDATA <= {24'h0, wd};
        @(posedge CLK);
        while (HREADYOUT !== 1'b1) @(posedge CLK);
        rv = HRDATA[7:0];
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp) begin
            err_total++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic rdc(input logic [7:0] ix, input logic [7:0] exp);
        xfer(1'b0, ix, 8'h00);
        chk(rv, exp);
    endtask
    task automatic report_and_stop;
        $display("comparisons %0d, mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    // Watchdog, well beyond the longest expected run
    initial begin
        repeat (60000) @(posedge CLK);
        err_total++;
        report_and_stop();
    end
    // ==========
    // Main sequence
    initial begin
        repeat (4) @(posedge CLK);
        RESET_N <= 1'b1;
        @(posedge CLK);
        foreach (ix_tab[i]) rdc(ix_tab[i], rst_tab[i]);
        // Writes to read-only and unmapped places are lost
        xfer(1'b1, 8'h0c, 8'hff);
        xfer(1'b1, 8'h1a, 8'hff);
        xfer(1'b1, 8'h19, 8'h5a);
        xfer(1'b1, 8'h1b, 8'hff);
        rdc(8'h0c, 8'h00);
        rdc(8'h1a, 8'h00);
        rdc(8'h19, 8'h5a);
        rdc(8'h1b, 8'h00);
        // Fast rate, port on, reception off: frame ignored
        xfer(1'b1, 8'h99, 8'h01);
        xfer(1'b1, 8'h98, 8'h04);
        xfer(1'b1, 8'h18, 8'h80);
        u_line.send(9'h0a5, 8, 1'b1, 32);
        rdc(8'h0c, 8'h00);
        xfer(1'b1, 8'h8c, 8'h20);
        xfer(1'b1, 8'h18, 8'h90);
        u_line.send(9'h03c, 8, 1'b1, 32);
        rdc(8'h0c, 8'h20);
        chk({7'h0, RX_IRQ}, 8'h01);
        rdc(8'h18, 8'h90);
        rdc(8'h1a, 8'h3c);
        rdc(8'h0c, 8'h00);
        repeat (2) @(posedge CLK);
        chk({7'h0, RX_IRQ}, 8'h00);
        // Masked request, full buffer, framing error, overrun
        xfer(1'b1, 8'h8c, 8'h00);
        u_line.send(9'h011, 8, 1'b1, 32);
        u_line.send(9'h022, 8, 1'b0, 32);
        u_line.send(9'h033, 8, 1'b1, 32);
        chk({7'h0, RX_IRQ}, 8'h00);
        rdc(8'h0c, 8'h20);
        rdc(8'h18, 8'h92);
        rdc(8'h1a, 8'h11);
        rdc(8'h18, 8'h96);
        rdc(8'h1a, 8'h22);
        rdc(8'h0c, 8'h00);
        u_line.send(9'h044, 8, 1'b1, 32);
        rdc(8'h0c, 8'h00);
        xfer(1'b1, 8'h18, 8'h80);
        rdc(8'h18, 8'h80);
        xfer(1'b1, 8'h18, 8'h90);
        u_line.send(9'h055, 8, 1'b1, 32);
        rdc(8'h18, 8'h90);
        rdc(8'h1a, 8'h55);
        // Nine data bits at the slow rate
        xfer(1'b1, 8'h98, 8'h00);
        xfer(1'b1, 8'h18, 8'hd0);
        u_line.send(9'h1a5, 9, 1'b1, 128);
        rdc(8'h18, 8'hd1);
        rdc(8'h1a, 8'ha5);
        // Clock master, one word from a line held high
        // Reception off first, so the mode change starts no word early
        xfer(1'b1, 8'h18, 8'h80);
        xfer(1'b1, 8'h98, 8'h90);
        xfer(1'b1, 8'h18, 8'ha0);
        tg = 0;
        sclk_l = SCLK_OUT;
        repeat (120) begin
            @(posedge CLK);
            if (SCLK_OUT !== sclk_l)
                tg++;
            sclk_l = SCLK_OUT;
        end
        chk(tg[7:0], 8'h10);
        chk({7'h0, SCLK_OE}, 8'h01);
        chk({7'h0, DATA_OE}, 8'h00);
        chk({6'h0, HRESP, DATA_OUT}, 8'h00);
        rdc(8'h18, 8'h80);
        rdc(8'h1a, 8'hff);
        report_and_stop();
    end
endmodule
